//--- adc_tail_pkg.sv
// constants for the channel 3 calibration tail of the register map
// assumes a 16-bit register map reached over the serial port
package adc_tail_pkg;
    localparam int          WORD_W         = 16;
    localparam int          ADDR_W         = 6;
    localparam int          TRIM_W         = 8;
    localparam int          COEF_W         = 24;
    localparam int          MAP_W          = 64;
    localparam logic [5:0]  ADDR_OFF_HIGH  = 6'h19;
    localparam logic [5:0]  ADDR_OFF_LOW   = 6'h1a;
    localparam logic [5:0]  ADDR_GAIN_HIGH = 6'h1b;
    localparam logic [5:0]  ADDR_GAIN_LOW  = 6'h1c;
    localparam logic [5:0]  ADDR_CHECKSUM  = 6'h3e;
    localparam logic [5:0]  ADDR_RESERVED  = 6'h3f;
    // command word: write flag in the top bit, address in the low bits
    localparam int          CMD_WRITE_BIT  = 15;
    localparam logic [3:0]  LAST_BIT       = 4'hf;
    localparam logic [15:0] OFF_HIGH_RST   = 16'h0000;
    localparam logic [7:0]  OFF_LOW_RST    = 8'h00;
    localparam logic [15:0] GAIN_HIGH_RST  = 16'h8000;
    localparam logic [7:0]  GAIN_LOW_RST   = 8'h00;
    localparam logic [15:0] CHECKSUM_RST   = 16'h0000;
    localparam logic [15:0] RESERVED_RST   = 16'h0000;
    localparam logic [7:0]  LOW_PAD        = 8'h00;
    localparam logic [15:0] CRC_POLY       = 16'h1021;
    localparam logic [15:0] CRC_INIT       = 16'hffff;
    localparam int          SAMPLE_PERIOD  = 1024;
endpackage

//--- map_checksum.sv
// combinational crc over the packed writable register map
// assumes the caller registers the result
`timescale 1ns/1ps
module map_checksum #(
    parameter int MAP_W = adc_tail_pkg::MAP_W
) (
    input  wire logic [MAP_W-1:0] mapBits,
    output logic      [15:0]      crcOut
);
    if (MAP_W < 1) begin : g_width_check
        $error("map width must be positive");
    end

    // msb first, one bit per step; cheap at this width
    always_comb begin
        logic [15:0] acc;
        logic        fb;
        acc = adc_tail_pkg::CRC_INIT;
        fb  = 1'b0;
        for (int i = MAP_W - 1; i >= 0; i--) begin
            fb  = acc[15] ^ mapBits[i];
            acc = {acc[14:0], 1'b0};
            if (fb) begin
                acc = acc ^ adc_tail_pkg::CRC_POLY;
            end
        end
        crcOut = acc;
    end
endmodule

//--- adc_cal_tail.sv
// channel 3 calibration registers, map checksum, shared serial port
// assumes pins are synchronous to clk_sys, which also serves as the
// converter master clock
//
// Contract
// - offset trim bits 7:0 sit in low word 15:8, read/write, reset 0.
// - low calibration words always read zero in bits 7:0.
// - gain trim bits 23:8 in writable word at 1Bh, reset 8000h.
// - gain trim bits 7:0 in upper byte of word 1Ch, reset 0.
// - read-only map checksum at 3Eh, reads zero after reset.
// - serial output is released whenever chip select is high.
// - devices sharing clock and sync convert at the same instants.
// - offset trim bits 23:8 in separate writable word, reset 0.
`timescale 1ns/1ps
module adc_cal_tail #(
    parameter int SAMPLE_PERIOD = adc_tail_pkg::SAMPLE_PERIOD
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic        din,
    output logic             dout,
    output logic             doutEn,
    input  wire logic        syncN,
    output logic             sampleReadyN,
    output logic      [23:0] ch3OffsetCoef,
    output logic      [23:0] ch3GainCoef
);
    localparam int CNT_W = $clog2(SAMPLE_PERIOD);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_PERIOD - 1);
    // two cycles would leave only one idle cycle between ready pulses
    if (SAMPLE_PERIOD < 3) begin : g_period_check
        $error("sample period must be at least three cycles");
    end

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_CMD  = 4'h2,
        S_DATA = 4'h4,
        S_DONE = 4'h8
    } port_state_t;

    port_state_t state_reg, state_next;
    logic        sclkPrev_reg, sclkPrev_next;
    logic [3:0]  bitCnt_reg, bitCnt_next;
    logic [15:0] shift_reg, shift_next;
    logic [15:0] tx_reg, tx_next;
    logic        dout_reg, dout_next;
    logic        cmdWrite_reg, cmdWrite_next;
    logic [5:0]  addr_reg, addr_next;
    logic        writeFire;
    logic [15:0] shiftIn;
    logic        sclkRise, sclkFall;
    logic [15:0] offHigh_reg, offHigh_next;
    logic [7:0]  offLow_reg, offLow_next;
    logic [15:0] gainHigh_reg, gainHigh_next;
    logic [7:0]  gainLow_reg, gainLow_next;
    logic [15:0] rsv_reg, rsv_next;
    logic [15:0] checksum_reg, checksum_next;
    logic        crcPending_reg, crcPending_next;
    logic [15:0] crcOut;
    logic [CNT_W-1:0] sampleCnt_reg, sampleCnt_next;
    logic             ready_reg, ready_next;
    // unmapped addresses read as zero
    function automatic logic [15:0] readWord(input logic [5:0] a);
        case (a)
            adc_tail_pkg::ADDR_OFF_HIGH:  readWord = offHigh_reg;
            adc_tail_pkg::ADDR_OFF_LOW:
                readWord = {offLow_reg, adc_tail_pkg::LOW_PAD};
            adc_tail_pkg::ADDR_GAIN_HIGH: readWord = gainHigh_reg;
            adc_tail_pkg::ADDR_GAIN_LOW:
                readWord = {gainLow_reg, adc_tail_pkg::LOW_PAD};
            adc_tail_pkg::ADDR_CHECKSUM:  readWord = checksum_reg;
            adc_tail_pkg::ADDR_RESERVED:  readWord = rsv_reg;
            default:                      readWord = 16'h0000;
        endcase
    endfunction
    assign sclkRise = sclk & ~sclkPrev_reg;
    assign sclkFall = ~sclk & sclkPrev_reg;
    assign shiftIn  = {shift_reg[14:0], din};
    // serial port: 16-bit command then 16-bit data, sampled on rising sclk
    always_comb begin
        state_next    = state_reg;
        sclkPrev_next = sclk;
        bitCnt_next   = bitCnt_reg;
        shift_next    = shift_reg;
        tx_next       = tx_reg;
        dout_next     = dout_reg;
        cmdWrite_next = cmdWrite_reg;
        addr_next     = addr_reg;
        writeFire     = 1'b0;
        case (state_reg)
            S_IDLE: begin
                bitCnt_next = 4'h0;
                dout_next   = 1'b0;
                if (!csN) begin
                    state_next = S_CMD;
                end
            end
            S_CMD: begin
                if (sclkRise) begin
                    shift_next  = shiftIn;
                    bitCnt_next = bitCnt_reg + 4'h1;
                    if (bitCnt_reg == adc_tail_pkg::LAST_BIT) begin
                        cmdWrite_next = shiftIn[adc_tail_pkg::CMD_WRITE_BIT];
                        addr_next     = shiftIn[5:0];
                        tx_next       = readWord(shiftIn[5:0]);
                        state_next    = S_DATA;
                    end
                end
            end
            S_DATA: begin
                // reply bits change on falling sclk, ahead of the next rise
                if (sclkFall) begin
                    dout_next = tx_reg[15];
                    tx_next   = {tx_reg[14:0], 1'b0};
                end
                if (sclkRise) begin
                    shift_next  = shiftIn;
                    bitCnt_next = bitCnt_reg + 4'h1;
                    if (bitCnt_reg == adc_tail_pkg::LAST_BIT) begin
                        writeFire  = cmdWrite_reg;
                        state_next = S_DONE;
                    end
                end
            end
            S_DONE: begin
                if (sclkFall) begin
                    dout_next = 1'b0;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        // a frame ends wherever select rises; a short frame writes nothing
        if (csN) begin
            state_next = S_IDLE;
            dout_next  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg    <= S_IDLE;
            sclkPrev_reg <= 1'b0;
            bitCnt_reg   <= 4'h0;
            shift_reg    <= 16'h0000;
            tx_reg       <= 16'h0000;
            dout_reg     <= 1'b0;
            cmdWrite_reg <= 1'b0;
            addr_reg     <= 6'h00;
        end else begin
            state_reg    <= state_next;
            sclkPrev_reg <= sclkPrev_next;
            bitCnt_reg   <= bitCnt_next;
            shift_reg    <= shift_next;
            tx_reg       <= tx_next;
            dout_reg     <= dout_next;
            cmdWrite_reg <= cmdWrite_next;
            addr_reg     <= addr_next;
        end
    end

    assign dout   = dout_reg;
    assign doutEn = ~csN;
    // register file; the reserved word stores whatever is written
    always_comb begin
        offHigh_next    = offHigh_reg;
        offLow_next     = offLow_reg;
        gainHigh_next   = gainHigh_reg;
        gainLow_next    = gainLow_reg;
        rsv_next        = rsv_reg;
        checksum_next   = checksum_reg;
        crcPending_next = writeFire;
        if (writeFire) begin
            case (addr_reg)
                adc_tail_pkg::ADDR_OFF_HIGH:
                    offHigh_next = shift_next;
                adc_tail_pkg::ADDR_OFF_LOW:
                    offLow_next = shift_next[15:8];
                adc_tail_pkg::ADDR_GAIN_HIGH:
                    gainHigh_next = shift_next;
                adc_tail_pkg::ADDR_GAIN_LOW:
                    gainLow_next = shift_next[15:8];
                adc_tail_pkg::ADDR_RESERVED:  rsv_next = shift_next;
                default: ;
            endcase
        end
        // refreshed one cycle after a write so it covers the new value
        if (crcPending_reg) begin
            checksum_next = crcOut;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            offHigh_reg    <= adc_tail_pkg::OFF_HIGH_RST;
            offLow_reg     <= adc_tail_pkg::OFF_LOW_RST;
            gainHigh_reg   <= adc_tail_pkg::GAIN_HIGH_RST;
            gainLow_reg    <= adc_tail_pkg::GAIN_LOW_RST;
            rsv_reg        <= adc_tail_pkg::RESERVED_RST;
            checksum_reg   <= adc_tail_pkg::CHECKSUM_RST;
            crcPending_reg <= 1'b0;
        end else begin
            offHigh_reg    <= offHigh_next;
            offLow_reg     <= offLow_next;
            gainHigh_reg   <= gainHigh_next;
            gainLow_reg    <= gainLow_next;
            rsv_reg        <= rsv_next;
            checksum_reg   <= checksum_next;
            crcPending_reg <= crcPending_next;
        end
    end

    map_checksum #(
        .MAP_W (adc_tail_pkg::MAP_W)
    ) u_checksum (
        .mapBits ({offHigh_reg, offLow_reg, gainHigh_reg, gainLow_reg,
                   rsv_reg}),
        .crcOut  (crcOut)
    );
    assign ch3OffsetCoef = {offHigh_reg, offLow_reg};
    assign ch3GainCoef   = {gainHigh_reg, gainLow_reg};
    // sample period timer; sync low holds it at zero so every device
    // released by the same strobe on the same clock ticks in step
    always_comb begin
        ready_next = 1'b1;
        if (!syncN) begin
            sampleCnt_next = '0;
        end else if (sampleCnt_reg == CNT_LAST) begin
            sampleCnt_next = '0;
            ready_next     = 1'b0;
        end else begin
            sampleCnt_next = sampleCnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sampleCnt_reg <= '0;
            ready_reg     <= 1'b1;
        end else begin
            sampleCnt_reg <= sampleCnt_next;
            ready_reg     <= ready_next;
        end
    end

    assign sampleReadyN = ready_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence cmdDone_s;
        state_reg == S_CMD && sclkRise && bitCnt_reg == adc_tail_pkg::LAST_BIT;
    endsequence
    sequence lowWordCmd_s;
        cmdDone_s ##0 (shiftIn[5:0] == adc_tail_pkg::ADDR_OFF_LOW ||
                       shiftIn[5:0] == adc_tail_pkg::ADDR_GAIN_LOW);
    endsequence

    offset_low_rst_a: assert property (
        $fell(rst) |-> offLow_reg == 8'h00 && offHigh_reg == 16'h0000)
        else $error("offset trim not cleared by reset");
    low_pad_zero_a: assert property (
        lowWordCmd_s |=> tx_reg[7:0] == 8'h00 && state_reg == S_DATA)
        else $error("low word reserved bits not zero");
    gain_high_wr_a: assert property (
        writeFire && addr_reg == adc_tail_pkg::ADDR_GAIN_HIGH
        |=> gainHigh_reg == $past(shift_next) ##1 $stable(gainHigh_reg))
        else $error("gain high word write lost");
    gain_low_wr_a: assert property (
        writeFire && addr_reg == adc_tail_pkg::ADDR_GAIN_LOW
        |=> ch3GainCoef[7:0] == $past(shift_next[15:8]))
        else $error("gain low byte write lost");
    checksum_update_a: assert property (
        writeFire |=> ##1 checksum_reg == $past(crcOut))
        else $error("checksum not refreshed after write");
    dout_release_a: assert property (
        csN |-> !doutEn ##1 !dout_reg)
        else $error("output driven while deselected");
    sync_align_a: assert property (
        !syncN |=> sampleCnt_reg == '0 && sampleReadyN)
        else $error("sync did not align sample timer");
    ready_period_a: assert property (
        !sampleReadyN |-> $past(sampleCnt_reg) == CNT_LAST
                          ##1 sampleReadyN [*2])
        else $error("sample ready at wrong instant");
    offset_high_wr_a: assert property (
        writeFire && addr_reg == adc_tail_pkg::ADDR_OFF_HIGH
        |=> ch3OffsetCoef[23:8] == $past(shift_next))
        else $error("offset high word write lost");
endmodule

//--- adc_host_model.sv
// host model: one select, serial clock and data toward the device
// assumes the device samples sclk on clk_sys, so each level lasts 2+ clks
`timescale 1ns/1ps
module adc_host_model (
    input  wire logic clk_sys,
    input  wire logic dout,
    output logic      csN,
    output logic      sclk,
    output logic      din
);
    initial begin
        // this host owns a single select, so two never go low
        // select rises between frames; never tied low on a shared bus
        csN  = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end

    // one frame, msb first; nBits below 32 aborts by raising select early
    // tracking conversions is left to sync and ready, not clocks
    task automatic xfer(input logic wr, input logic [5:0] addr,
                        input logic [15:0] wdata, input int nBits,
                        output logic [15:0] rdata);
        logic [31:0] frame;
        frame = {wr, 9'h000, addr, wdata};
        rdata = 16'h0000;
        @(posedge clk_sys);
        csN <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < nBits; i++) begin
            @(negedge clk_sys);
            // data bit changes on the same clk edge as the rise that samples it
            if (i >= 16) rdata[31-i] = dout;
            @(posedge clk_sys);
            din  <= frame[31-i];
            sclk <= 1'b1;
            repeat (2) @(posedge clk_sys);
            sclk <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        csN <= 1'b1;
        din <= ~din;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule

//--- tb_adc_cal_tail.sv
// self-checking bench for the channel 3 calibration tail
// assumes the host model drives the serial pins; sample period shortened
`timescale 1ns/1ps
module tb_adc_cal_tail;
    localparam int PER = 8;
    logic        clk_sys;
    logic        rst;
    logic        csN;
    logic        sclk;
    logic        din;
    logic        dout;
    logic        doutEn;
    logic        syncN;
    logic        sampleReadyN;
    logic [23:0] ch3OffsetCoef;
    logic [23:0] ch3GainCoef;
    logic [15:0] rd;
    logic [15:0] crcSeen;
    int          mismatches;
    int          checked;

    adc_cal_tail #(.SAMPLE_PERIOD(PER)) uut (
        .clk_sys(clk_sys), .rst(rst), .csN(csN), .sclk(sclk), .din(din),
        .dout(dout), .doutEn(doutEn), .syncN(syncN),
        .sampleReadyN(sampleReadyN), .ch3OffsetCoef(ch3OffsetCoef),
        .ch3GainCoef(ch3GainCoef));

    adc_host_model host (
        .clk_sys(clk_sys), .dout(dout), .csN(csN), .sclk(sclk), .din(din));

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdReg(input logic [5:0] a);
        host.xfer(1'b0, a, 16'h0000, 32, rd);
    endtask

    task automatic wrReg(input logic [5:0] a, input logic [15:0] d);
        host.xfer(1'b1, a, d, 32, rd);
    endtask

    // output enable follows the select on every cycle, frames included
    always @(negedge clk_sys) begin
        if (!rst) chk("doutEn", {23'h0, ~csN}, {23'h0, doutEn});
    end

    // reference crc of the writable words, msb first
    function automatic logic [15:0] mapCrc(
            input logic [adc_tail_pkg::MAP_W-1:0] m);
        logic [15:0] acc;
        acc = adc_tail_pkg::CRC_INIT;
        for (int i = adc_tail_pkg::MAP_W - 1; i >= 0; i--) begin
            if (acc[15] ^ m[i]) begin
                acc = {acc[14:0], 1'b0} ^ adc_tail_pkg::CRC_POLY;
            end else begin
                acc = {acc[14:0], 1'b0};
            end
        end
        return acc;
    endfunction

    task automatic t_reset_values();
        rdReg(adc_tail_pkg::ADDR_OFF_HIGH);
        chk("offHigh rst", 24'h0, rd);
        rdReg(adc_tail_pkg::ADDR_OFF_LOW);
        chk("offLow rst", 24'h0, rd);
        rdReg(adc_tail_pkg::ADDR_GAIN_HIGH);
        chk("gainHigh rst", 24'h8000, rd);
        rdReg(adc_tail_pkg::ADDR_GAIN_LOW);
        chk("gainLow rst", 24'h0, rd);
        rdReg(adc_tail_pkg::ADDR_CHECKSUM);
        chk("checksum rst", 24'h0, rd);
        rdReg(adc_tail_pkg::ADDR_RESERVED);
        chk("reserved rst", 24'h0, rd);
        chk("gain coef rst", 24'h800000, ch3GainCoef);
        chk("offset coef rst", 24'h0, ch3OffsetCoef);
    endtask

    task automatic t_write_read();
        wrReg(adc_tail_pkg::ADDR_OFF_HIGH, 16'ha5c3);
        wrReg(adc_tail_pkg::ADDR_OFF_LOW, 16'h5aff);
        wrReg(adc_tail_pkg::ADDR_GAIN_HIGH, 16'h1234);
        wrReg(adc_tail_pkg::ADDR_GAIN_LOW, 16'hbeef);
        rdReg(adc_tail_pkg::ADDR_OFF_HIGH);
        chk("offHigh", 24'ha5c3, rd);
        rdReg(adc_tail_pkg::ADDR_OFF_LOW);
        chk("offLow", 24'h5a00, rd);
        rdReg(adc_tail_pkg::ADDR_GAIN_HIGH);
        chk("gainHigh", 24'h1234, rd);
        rdReg(adc_tail_pkg::ADDR_GAIN_LOW);
        chk("gainLow", 24'hbe00, rd);
        chk("offset coef", 24'ha5c35a, ch3OffsetCoef);
        chk("gain coef", 24'h1234be, ch3GainCoef);
    endtask

    task automatic t_checksum_ro();
        rdReg(adc_tail_pkg::ADDR_CHECKSUM);
        crcSeen = rd;
        chk("checksum loaded", 24'h1, {23'h0, rd !== 16'h0});
        chk("checksum value", {8'h0, mapCrc({16'ha5c3, 8'h5a, 16'h1234,
            8'hbe, 16'h0000})}, rd);
        wrReg(adc_tail_pkg::ADDR_CHECKSUM, ~crcSeen);
        rdReg(adc_tail_pkg::ADDR_CHECKSUM);
        chk("checksum ro", {8'h0, crcSeen}, rd);
    endtask

    // a frame cut one bit short must leave the register alone
    task automatic t_abort();
        host.xfer(1'b1, adc_tail_pkg::ADDR_GAIN_HIGH, 16'h0f0f, 31, rd);
        rdReg(adc_tail_pkg::ADDR_GAIN_HIGH);
        chk("aborted write", 24'h1234, rd);
    endtask

    task automatic t_reserved();
        wrReg(adc_tail_pkg::ADDR_RESERVED, 16'h0000);
        rdReg(adc_tail_pkg::ADDR_RESERVED);
        chk("reserved", 24'h0, rd);
        rdReg(6'h05);
        chk("unmapped", 24'h0, rd);
    endtask

    task automatic t_sync();
        int n;
        @(posedge clk_sys);
        syncN <= 1'b0;
        repeat (3) @(posedge clk_sys);
        syncN <= 1'b1;
        n = 0;
        while (sampleReadyN !== 1'b0 && n < 4 * PER) begin
            @(negedge clk_sys);
            n++;
        end
        chk("first ready", 24'h1,
            {23'h0, n >= PER - 1 && n <= PER + 2});
        @(negedge clk_sys);
        chk("ready width", 24'h1, {23'h0, sampleReadyN});
        n = 1;
        while (sampleReadyN !== 1'b0 && n < 4 * PER) begin
            @(negedge clk_sys);
            n++;
        end
        chk("ready period", PER, n);
    endtask

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a frame takes about 200 clks; the whole run needs under 6000
    initial begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end

    initial begin
        mismatches = 0;
        checked    = 0;
        rst        = 1'b1;
        syncN      = 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_values();
        t_write_read();
        t_checksum_ro();
        t_abort();
        t_reserved();
        t_sync();
        end_of_test();
    end
endmodule
